/* File: core/hcs_status.v */
`timescale 1ns/100ps
`default_nettype none
`include "hcs_consts.vh"
module hcs_status (
  input  wire        clk,
  input  wire        resetn,
  input  wire        host_wr_idr,
  input  wire [2:0]  host_addr,
  input  wire [7:0]  host_wdata,
  input  wire        host_rd_odr,
  input  wire        host_rd_str,
  output reg  [7:0]  host_rdata,
  output wire        host_wr_ready,
  input  wire        slv_rd_idr,
  output wire [7:0]  slv_idr_data,
  output wire        slv_idr_valid,
  input  wire        slv_wr_odr,
  input  wire [7:0]  slv_wdata,
  input  wire        slv_wr_str,
  output wire [7:0]  slv_str,
  output wire        slv_irq
);
  localparam FW = `HCS_FIFO_W;

  reg  [7:0]    host_to_slave_data_reg_q;
  reg  [7:0]    host_to_slave_data_reg_d;
  reg  [7:0]    slave_to_host_data_reg_q;
  reg  [7:0]    slave_to_host_data_reg_d;
  reg           command_not_data_flag_q;
  reg           command_not_data_flag_d;
  reg           inbound_full_flag_q;
  reg           inbound_full_flag_d;
  reg           outbound_full_flag_q;
  reg           outbound_full_flag_d;
  reg  [7:0]    user_q;
  reg  [7:0]    user_d;
  reg  [7:0]    host_rdata_d;
  wire [FW-1:0] fifo_in_word;
  wire [FW-1:0] fifo_out;
  wire          fifo_valid;
  wire          fifo_in_ready;
  wire          fifo_pop;
  wire [7:0]    status_word;

  // head loads only into an empty inbound register, so a load never meets a slave read of a full one
  assign fifo_pop     = !inbound_full_flag_q && fifo_valid;
  assign fifo_in_word = {host_addr[`HCS_HOST_ADDR_CD], host_wdata};

  // fifo soaks back-to-back host writes; ready stalls the host when it fills
  hcs_fifo #(
    .W  (FW),
    .D  (`HCS_FIFO_DEPTH),
    .AW (`HCS_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_data   (fifo_in_word),
    .in_valid  (host_wr_idr),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign host_wr_ready = fifo_in_ready;

  // status byte assembled bit by bit
  assign status_word[`HCS_USER_HI:`HCS_USER_LO] = user_q[`HCS_USER_HI:`HCS_USER_LO];
  assign status_word[`HCS_BIT_CD]  = command_not_data_flag_q;
  assign status_word[`HCS_BIT_U2]  = user_q[`HCS_BIT_U2];
  assign status_word[`HCS_BIT_IBF] = inbound_full_flag_q;
  assign status_word[`HCS_BIT_OBF] = outbound_full_flag_q;

  assign slv_str       = status_word;
  assign slv_irq       = inbound_full_flag_q;
  assign slv_idr_data  = host_to_slave_data_reg_q;
  assign slv_idr_valid = inbound_full_flag_q;

  // inbound full: cleared by slave read, set when the fifo head lands
  always @* begin
    inbound_full_flag_d = inbound_full_flag_q;
    if (slv_rd_idr) begin
      inbound_full_flag_d = 1'b0;
    end
    if (fifo_pop) begin
      inbound_full_flag_d = 1'b1;
    end
  end

  // inbound data and command bit travel together from the fifo
  always @* begin
    host_to_slave_data_reg_d = host_to_slave_data_reg_q;
    command_not_data_flag_d  = command_not_data_flag_q;
    if (fifo_pop) begin
      host_to_slave_data_reg_d = fifo_out[`HCS_DATA_HI:0];
      command_not_data_flag_d  = fifo_out[`HCS_FIFO_CD];
    end
  end

  // outbound full: slave may only clear; a new outbound write wins
  always @* begin
    outbound_full_flag_d = outbound_full_flag_q;
    if (slv_wr_str && !slv_wdata[`HCS_BIT_OBF]) begin
      outbound_full_flag_d = 1'b0;
    end
    if (host_rd_odr) begin
      outbound_full_flag_d = 1'b0;
    end
    if (slv_wr_odr) begin
      outbound_full_flag_d = 1'b1;
    end
  end

  always @* begin
    slave_to_host_data_reg_d = slave_to_host_data_reg_q;
    if (slv_wr_odr) begin
      slave_to_host_data_reg_d = slv_wdata;
    end
  end

  // read-only bits masked off so a slave write cannot reach them
  always @* begin
    user_d = user_q;
    if (slv_wr_str) begin
      user_d = slv_wdata & `HCS_USER_MASK;
    end
  end

  // status read has no side effect; only the data read clears a flag
  always @* begin
    host_rdata_d = host_rdata;
    if (host_rd_str) begin
      host_rdata_d = status_word;
    end else if (host_rd_odr) begin
      host_rdata_d = slave_to_host_data_reg_q;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inbound_full_flag_q <= 1'b0;
    end else begin
      inbound_full_flag_q <= inbound_full_flag_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      command_not_data_flag_q <= 1'b0;
    end else begin
      command_not_data_flag_q <= command_not_data_flag_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      host_to_slave_data_reg_q <= `HCS_RST8;
    end else begin
      host_to_slave_data_reg_q <= host_to_slave_data_reg_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outbound_full_flag_q <= 1'b0;
    end else begin
      outbound_full_flag_q <= outbound_full_flag_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slave_to_host_data_reg_q <= `HCS_RST8;
    end else begin
      slave_to_host_data_reg_q <= slave_to_host_data_reg_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      user_q <= `HCS_RST8;
    end else begin
      user_q <= user_d;
    end
  end

  // read data held until the next host read
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      host_rdata <= `HCS_RST8;
    end else begin
      host_rdata <= host_rdata_d;
    end
  end
endmodule // hcs_status
`default_nettype wire

/* File: core/hcs_consts.vh */
`ifndef HCS_CONSTS_VH
`define HCS_CONSTS_VH
`define HCS_W              8
`define HCS_BIT_OBF        0
`define HCS_BIT_IBF        1
`define HCS_BIT_U2         2
`define HCS_BIT_CD         3
`define HCS_USER_MASK      8'hF4
`define HCS_RST8           8'h00
`define HCS_HOST_ADDR_CD   2
`define HCS_FIFO_DEPTH     8
`define HCS_FIFO_AW        3
`define HCS_FIFO_W         9
`define HCS_FIFO_CD        8
`define HCS_DATA_HI        7
`define HCS_USER_HI        7
`define HCS_USER_LO        4
`endif

/* File: core/hcs_fifo.v */
`timescale 1ns/100ps
`default_nettype none
module hcs_fifo #(
  parameter W  = 9,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire          clk,
  input  wire          resetn,
  input  wire [W-1:0]  in_data,
  input  wire          in_valid,
  output wire          in_ready,
  output wire [W-1:0]  out_data,
  output wire          out_valid,
  input  wire          out_ready
);
  localparam [AW:0] FULL_CNT = D;
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0]   cnt_q;
  wire         wr = in_valid && in_ready;
  wire         rd = out_valid && out_ready;
  assign in_ready  = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rp_q];
  always @(posedge clk) begin
    if (wr) begin
      mem[wp_q] <= in_data;
    end
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (wr) begin
        wp_q <= wp_q + 1'b1;
      end
      if (rd) begin
        rp_q <= rp_q + 1'b1;
      end
      if (wr && !rd) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (rd && !wr) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // hcs_fifo
`default_nettype wire

/* File: sim/hcs_status_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module hcs_status_monitor (
  input wire logic       clk, resetn, host_rd_odr, host_rd_str, slv_rd_idr,
  input wire logic       slv_wr_odr, slv_wr_str, slv_irq,
  input wire logic [7:0] host_rdata, slv_wdata, slv_str
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_held; slv_str[1] && !slv_rd_idr; endsequence
  property p_irq; slv_irq == slv_str[1]; endproperty
  a_irq: assert property (p_irq) else $error("irq differs");
  property p_ibf_clr; slv_rd_idr && slv_str[1] |=> !slv_str[1]; endproperty
  a_ibf_clr: assert property (p_ibf_clr) else $error("inbound kept");
  property p_obf_set; slv_wr_odr |=> slv_str[0]; endproperty
  a_obf_set: assert property (p_obf_set) else $error("outbound not set");
  property p_obf_clr; host_rd_odr && !slv_wr_odr |=> !slv_str[0]; endproperty
  a_obf_clr: assert property (p_obf_clr) else $error("outbound kept");
  property p_w1; slv_wr_str && slv_wdata[0] && !slv_wr_odr && !host_rd_odr |=> $stable(slv_str[0]);
  endproperty
  a_w1: assert property (p_w1) else $error("outbound moved");
  property p_user; slv_wr_str |=> (slv_str & 8'hF4) == ($past(slv_wdata) & 8'hF4); endproperty
  a_user: assert property (p_user) else $error("user bits wrong");
  property p_ro; s_held |=> slv_str[1] && $stable(slv_str[3]); endproperty
  a_ro: assert property (p_ro) else $error("flag moved");
  property p_rd; host_rd_str |=> host_rdata == $past(slv_str); endproperty
  a_rd: assert property (p_rd) else $error("status read wrong");
endmodule // hcs_status_monitor
bind hcs_status hcs_status_monitor hcs_status_monitor_inst (.clk, .resetn, .host_rd_odr,
  .host_rd_str, .slv_rd_idr, .slv_wr_odr, .slv_wr_str, .slv_irq, .host_rdata, .slv_wdata, .slv_str);
`default_nettype wire

/* File: sim/hcs_host.sv */
`timescale 1ns/100ps
`default_nettype none
module hcs_host (
  input wire logic        clk, host_wr_ready,
  output var logic        host_wr_idr = 0, host_rd_odr = 0, host_rd_str = 0,
  output var logic [2:0]  host_addr = 3'h0,
  output var logic [7:0]  host_wdata = 8'h00
);
  // strobe left high between writes so back-to-back cycles stay glitch free
  task wr(logic [2:0] a, logic [7:0] d);
    #2 host_addr = a; host_wdata = d; host_wr_idr = 1;
    @(posedge clk iff host_wr_ready);
  endtask
  // released bus shows inverted data, never a stale copy
  task idle(); #2 host_wr_idr = 0; host_addr = ~host_addr; host_wdata = ~host_wdata; endtask
  task rd(logic o);
    #2 host_rd_odr = o; host_rd_str = !o;
    @(posedge clk);
    #2 host_rd_odr = 0; host_rd_str = 0;
  endtask
endmodule // hcs_host
`default_nettype wire

/* File: sim/hcs_status_test.sv */
`timescale 1ns/100ps
`default_nettype none
module hcs_status_test;
  logic clk = 0, resetn = 0, slv_rd_idr = 0, slv_wr_odr = 0, slv_wr_str = 0, stall = 1, c;
  logic [7:0] slv_wdata = 8'h00, a, d;
  logic [31:0] rs = 58;
  logic [8:0] q[$];
  int fails = 0, num_checks = 0, cyc = 0;
  wire [7:0] host_rdata, slv_idr_data, slv_str, host_wdata;
  wire [2:0] host_addr;
  wire host_wr_idr, host_rd_odr, host_rd_str, host_wr_ready, slv_idr_valid, slv_irq;
  always #25 clk = ~clk;
  hcs_host hcs_host_inst (.*);
  hcs_status hcs_status_inst (.*);
  function logic [7:0] rnd(); rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5; return rs[7:0];
  endfunction
  task chk(string n, logic [8:0] s, e);
    num_checks++;
    if (s !== e) begin fails++; $display("CHECK FAILED %s exp %h seen %h", n, e, s); end
  endtask
  task finish_test();
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task slv(logic o, s, logic [7:0] v);
    #2 slv_wr_odr = o; slv_wr_str = s; slv_wdata = v;
    @(posedge clk);
    #2 slv_wr_odr = 0; slv_wr_str = 0;
  endtask
  // slave side drains inbound data, compares it with the oldest note
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin fails++; finish_test(); end
    slv_rd_idr <= 0;
    if (slv_idr_valid === 1'b1 && !slv_rd_idr && !stall) begin
      chk("inbound", {slv_str[3], slv_idr_data}, q.pop_front());
      slv_rd_idr <= 1;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #2 resetn = 1;
    chk("reset", slv_str, 9'h000);
    repeat (9) begin
      a = rnd(); d = rnd(); c = a[2]; q.push_back({c, d}); hcs_host_inst.wr(a[2:0], d);
    end
    hcs_host_inst.idle();
    @(posedge clk); #2 chk("full", host_wr_ready, 9'h000);
    stall = 0;
    wait (q.size() == 0); repeat (3) @(posedge clk);
    chk("drained", {slv_irq, slv_str}, {5'h00, c, 3'h0});
    d = rnd(); slv(1, 0, d); hcs_host_inst.rd(0);
    chk("status", host_rdata, {5'h00, c, 3'h1});
    slv(0, 1, 8'hFF); hcs_host_inst.rd(0);
    chk("user", host_rdata, {5'h0F, c, 3'h5});
    hcs_host_inst.rd(1);
    chk("odr", {slv_str[0], host_rdata}, {1'b0, d});
    slv(1, 0, d); slv(0, 1, 8'h00);
    chk("clear", slv_str, {5'h00, c, 3'h0});
    finish_test();
  end
endmodule // hcs_status_test
`default_nettype wire
